// >>> design/modulator_control.sv
// modulator control register bank with optional synchronous loading
// assumes latch strobe, address and shifter data arrive from the serial
// port asynchronously; the phase detector clock is a sampled pin
`timescale 1ns/1ps
`default_nettype none
module modulator_control
   import modctl_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic serial_latch_enable_i,
   input wire logic [4:0] wr_addr_i,
   input wire logic [23:0] wr_data_i,
   input wire logic phase_detector_clock_i,
   input wire logic [4:0] rd_addr_i,
   output logic [23:0] rd_data_o,
   output logic [23:0] modcfg_o,
   output logic [18:0] int_setting_o,
   output logic [23:0] frac_setting_o,
   output logic [23:0] aux1a_o,
   output logic [1:0] order_o,
   output logic order_valid_o,
   output logic exact_freq_en_o,
   output logic mod_to_divider_o,
   output logic mod_clock_en_o,
   output logic core_en_o,
   output logic seed_load_o,
   output logic freq_update_o,
   output logic sync_busy_o
);
   logic latch_s, latch_rise, pd_s, pd_rise;
   logic [4:0] addr_s1_q, addr_s2_q;
   logic [23:0] data_s1_q, data_s2_q;
   logic [23:0] modcfg_q, int_q, frac_q, aux1a_q;
   logic [4:0] hold_addr_q;
   logic [23:0] hold_data_q;
   load_state_t ld_q;
   logic commit_now, commit_held;
   logic [4:0] c_addr;
   logic [23:0] c_data;

   sync2 u_sync_latch (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .d_i(serial_latch_enable_i),
      .q_o(latch_s)
   );
   pd_edge u_latch_edge (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .level_i(latch_s),
      .rise_o(latch_rise)
   );
   sync2 u_sync_pd (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .d_i(phase_detector_clock_i),
      .q_o(pd_s)
   );
   pd_edge u_pd_edge (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .level_i(pd_s),
      .rise_o(pd_rise)
   );

   // bus words are quasi-static around the latch edge; two flops keep
   // them aligned with the synchronised strobe
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         addr_s1_q <= 5'h00;
         addr_s2_q <= 5'h00;
         data_s1_q <= 24'h000000;
         data_s2_q <= 24'h000000;
      end else begin
         addr_s1_q <= wr_addr_i;
         addr_s2_q <= addr_s1_q;
         data_s1_q <= wr_data_i;
         data_s2_q <= data_s1_q;
      end
   end

   // direct load when sync bit clear or address not retimed
   always_comb begin
      commit_now = latch_rise &&
         (!modcfg_q[SYNC_BIT] || !is_retimed(addr_s2_q));
      commit_held = (ld_q == LD_XFER);
      if (commit_held) begin
         c_addr = hold_addr_q;
         c_data = hold_data_q;
      end else begin
         c_addr = addr_s2_q;
         c_data = data_s2_q;
      end
   end

   // retiming: capture at latch, transfer on next detector clock edge.
   // host keeps the shifter still two detector periods
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         ld_q <= LD_IDLE;
         hold_addr_q <= 5'h00;
         hold_data_q <= 24'h000000;
      end else begin
         case (ld_q)
            LD_IDLE: begin
               if (latch_rise && modcfg_q[SYNC_BIT] &&
                   is_retimed(addr_s2_q)) begin
                  hold_addr_q <= addr_s2_q;
                  hold_data_q <= data_s2_q;
                  ld_q <= LD_WAIT;
               end
            end
            LD_WAIT: begin
               if (pd_rise) begin
                  ld_q <= LD_XFER;
               end
            end
            LD_XFER: begin
               ld_q <= LD_IDLE;
            end
            default: begin
               ld_q <= LD_IDLE;
            end
         endcase
      end
   end

   // register file; all bits stored as written, reserved included
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         modcfg_q <= MODCFG_RST;
         int_q <= INT_RST;
         frac_q <= FRAC_RST;
         aux1a_q <= AUX1A_RST;
      end else if (commit_now || commit_held) begin
         case (c_addr)
            ADDR_MODCFG: modcfg_q <= c_data;
            ADDR_INT: int_q <= c_data;
            ADDR_FRAC: frac_q <= c_data;
            ADDR_AUX1A: aux1a_q <= c_data;
            default: begin
            end
         endcase
      end
   end

   // seed reload pulse only with auto-seed; else phase carries on
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         seed_load_o <= 1'b0;
         freq_update_o <= 1'b0;
      end else begin
         seed_load_o <= (commit_now || commit_held) &&
            (c_addr == ADDR_FRAC) && modcfg_q[SEED_BIT];
         freq_update_o <= (commit_now || commit_held) &&
            (c_addr == ADDR_FRAC || c_addr == ADDR_INT);
      end
   end

   // decoded controls
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         order_o <= ORD_THIRD;
         order_valid_o <= 1'b1;
         exact_freq_en_o <= 1'b0;
         mod_to_divider_o <= 1'b1;
         mod_clock_en_o <= 1'b1;
         core_en_o <= 1'b1;
      end else begin
         order_o <= modcfg_q[ORDER_LSB +: 2];
         order_valid_o <= modcfg_q[ORDER_LSB +: 2] != ORDER_RESERVED;
         exact_freq_en_o <= modcfg_q[EXACT_BIT];
         // divider sees modulator only when not bypassed and core on
         mod_to_divider_o <= !modcfg_q[BYPASS_BIT] &&
            modcfg_q[CORE_BIT];
         // clocking follows core enable, independent of bypass
         mod_clock_en_o <= modcfg_q[CORE_BIT];
         core_en_o <= modcfg_q[CORE_BIT];
      end
   end

   // register images and readback
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         rd_data_o <= 24'h000000;
         modcfg_o <= MODCFG_RST;
         int_setting_o <= INT_RST[18:0];
         frac_setting_o <= FRAC_RST;
         aux1a_o <= AUX1A_RST;
         sync_busy_o <= 1'b0;
      end else begin
         modcfg_o <= modcfg_q;
         int_setting_o <= int_q[18:0];
         frac_setting_o <= frac_q;
         aux1a_o <= aux1a_q;
         sync_busy_o <= (ld_q != LD_IDLE);
         case (rd_addr_i)
            ADDR_MODCFG: rd_data_o <= modcfg_q;
            ADDR_INT: rd_data_o <= {5'h00, int_q[18:0]};
            ADDR_FRAC: rd_data_o <= frac_q;
            ADDR_AUX1A: rd_data_o <= aux1a_q;
            default: rd_data_o <= 24'h000000;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> design/modctl_pkg.sv
// modulator control package: register map, field layout, reset values
// assumes a serial write word of 5-bit address plus 24-bit data
package modctl_pkg;
   localparam int unsigned DATA_W = 24;
   localparam int unsigned ADDR_W = 5;
   localparam logic [4:0] ADDR_INT = 5'h03;
   localparam logic [4:0] ADDR_FRAC = 5'h04;
   localparam logic [4:0] ADDR_MODCFG = 5'h06;
   localparam logic [4:0] ADDR_AUX1A = 5'h1a;
   localparam logic [23:0] MODCFG_RST = 24'h030f0a;
   localparam logic [23:0] INT_RST = 24'h000019;
   localparam logic [23:0] FRAC_RST = 24'h000000;
   localparam logic [23:0] AUX1A_RST = 24'h000000;
   localparam int unsigned ORDER_LSB = 2;
   localparam int unsigned SYNC_BIT = 4;
   localparam int unsigned EXACT_BIT = 5;
   localparam int unsigned BYPASS_BIT = 7;
   localparam int unsigned SEED_BIT = 8;
   localparam int unsigned CORE_BIT = 11;
   localparam int unsigned FRAC_W = 24;
   localparam logic [1:0] ORDER_RESERVED = 2'h3;

   typedef enum logic [2:0] {
      LD_IDLE = 3'b001,
      LD_WAIT = 3'b010,
      LD_XFER = 3'b100
   } load_state_t;

   typedef enum logic [1:0] {
      ORD_FIRST = 2'h0,
      ORD_SECOND = 2'h1,
      ORD_THIRD = 2'h2,
      ORD_RSVD = 2'h3
   } order_t;

   function automatic logic is_retimed(input logic [4:0] a);
      return (a == ADDR_INT) || (a == ADDR_FRAC) || (a == ADDR_AUX1A);
   endfunction
endpackage

// >>> design/sync2.sv
// two-flop level synchroniser
// assumes d_i comes from outside the ref_clk_i domain
`timescale 1ns/1ps
`default_nettype none
module sync2 (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic d_i,
   output logic q_o
);
   logic meta_q;
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         meta_q <= 1'b0;
         q_o <= 1'b0;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule
`default_nettype wire

// >>> design/pd_edge.sv
// rising-edge detector on an already synchronised level
// assumes input is in the ref_clk_i domain
`timescale 1ns/1ps
`default_nettype none
module pd_edge (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic level_i,
   output logic rise_o
);
   logic last_q;
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         last_q <= 1'b0;
      end else begin
         last_q <= level_i;
      end
   end
   assign rise_o = level_i & ~last_q;
endmodule
`default_nettype wire

// >>> sim/modctl_monitor.sv
// checker for the modulator control register bank outputs
// assumes one clock domain, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module modctl_monitor
   import modctl_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic [23:0] modcfg_o,
   input wire logic [18:0] int_setting_o,
   input wire logic [23:0] frac_setting_o,
   input wire logic [1:0] order_o,
   input wire logic order_valid_o,
   input wire logic exact_freq_en_o,
   input wire logic mod_to_divider_o,
   input wire logic mod_clock_en_o,
   input wire logic core_en_o,
   input wire logic seed_load_o,
   input wire logic sync_busy_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_rst_end;
      $fell(sys_rst_i);
   endsequence
   sequence s_seed;
      seed_load_o && modcfg_o[SEED_BIT];
   endsequence
   property p_rst;
      s_rst_end |-> modcfg_o == MODCFG_RST && frac_setting_o == FRAC_RST
         && int_setting_o == INT_RST[18:0];
   endproperty
   property p_order;
      order_o == modcfg_o[3:2];
   endproperty
   property p_valid;
      order_valid_o == (modcfg_o[3:2] != ORDER_RESERVED);
   endproperty
   property p_exact;
      exact_freq_en_o == modcfg_o[EXACT_BIT];
   endproperty
   property p_div;
      mod_to_divider_o == (!modcfg_o[BYPASS_BIT] && modcfg_o[CORE_BIT]);
   endproperty
   property p_clk;
      mod_clock_en_o == modcfg_o[CORE_BIT];
   endproperty
   property p_core;
      core_en_o == modcfg_o[CORE_BIT];
   endproperty
   // a seed pulse without auto-seed would reseed the phase
   property p_seed;
      seed_load_o |-> s_seed ##1 !seed_load_o;
   endproperty
   property p_busy;
      $rose(sync_busy_o) |-> modcfg_o[SYNC_BIT];
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset image");
   a_order: assert property (p_order) else $error("bad order");
   a_valid: assert property (p_valid) else $error("bad valid");
   a_exact: assert property (p_exact) else $error("bad exact");
   a_div: assert property (p_div) else $error("bad divider");
   a_clk: assert property (p_clk) else $error("bad mod clock");
   a_core: assert property (p_core) else $error("bad core");
   a_seed: assert property (p_seed) else $error("bad seed");
   a_busy: assert property (p_busy) else $error("bad retime");
endmodule
bind modulator_control modctl_monitor u_mon (.*);
`default_nettype wire

// >>> sim/serial_host_model.sv
// serial host model: shifts one word, pulses the latch, runs detector clk
// assumes the bench calls send from a single process
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
   input wire logic ref_clk_i,
   output logic latch_o,
   output logic [4:0] addr_o,
   output logic [23:0] data_o,
   output logic pd_clk_o
);
   initial begin
      latch_o = 1'b0;
      addr_o = 5'h00;
      data_o = 24'h000000;
      pd_clk_o = 1'b0;
   end
   always #350 pd_clk_o = ~pd_clk_o;
   task automatic send(input logic [4:0] a, input logic [23:0] d);
      @(posedge ref_clk_i);
      #1 addr_o = a;
      data_o = d;
      repeat (4) @(posedge ref_clk_i);
      #1 latch_o = 1'b1;
      // word held well past two detector periods
      repeat (20) @(posedge ref_clk_i);
      #1 latch_o = 1'b0;
      // shifter moves on once the latch drops
      addr_o = ~a;
      data_o = ~d;
   endtask
endmodule
`default_nettype wire

// >>> sim/modulator_control_tb_top.sv
// self-checking bench for the modulator control register bank
// assumes the host model drives latch, word and detector clock
`timescale 1ns/1ps
`default_nettype none
module modulator_control_tb_top
   import modctl_pkg::*;
;
   logic ref_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [4:0] rd_addr_i = 5'h06;
   logic latch;
   logic pd_clk;
   logic [4:0] wa;
   logic [23:0] wd;
   logic [23:0] v;
   int num_errors = 0;
   int checks_done = 0;
   int n_seed = 0;
   int n_busy = 0;
   int n_upd = 0;
   always #50 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      n_seed += (uut.seed_load_o === 1'b1);
      n_busy += (uut.sync_busy_o === 1'b1);
      n_upd += (uut.freq_update_o === 1'b1);
   end
   serial_host_model host (.ref_clk_i(ref_clk_i), .latch_o(latch),
      .addr_o(wa), .data_o(wd), .pd_clk_o(pd_clk));
   modulator_control uut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .serial_latch_enable_i(latch), .wr_addr_i(wa), .wr_data_i(wd),
      .phase_detector_clock_i(pd_clk), .rd_addr_i(rd_addr_i),
      .rd_data_o(), .modcfg_o(), .int_setting_o(), .frac_setting_o(),
      .aux1a_o(), .order_o(), .order_valid_o(), .exact_freq_en_o(),
      .mod_to_divider_o(), .mod_clock_en_o(), .core_en_o(),
      .seed_load_o(), .freq_update_o(), .sync_busy_o());
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic t_reset;
      chk(uut.modcfg_o, MODCFG_RST);
      chk(uut.int_setting_o, INT_RST);
      // third order (2), order valid, core on
      chk({uut.order_o, uut.order_valid_o, uut.core_en_o}, 24'h00000b);
   endtask
   // every order code, with exact, bypass and core varied alongside
   task automatic t_modes;
      for (int k = 0; k < 4; k++) begin
         v = {12'h030, k != 2, 3'h0, k[1], 1'b0, k[0], 1'b0, k[1:0], 2'h0};
         host.send(ADDR_MODCFG, v);
         chk(uut.modcfg_o, v);
         chk(uut.order_o, k[1:0]);
         chk(uut.order_valid_o, k != 3);
         chk(uut.exact_freq_en_o, v[5]);
         chk(uut.mod_to_divider_o, !v[7] && v[11]);
         chk(uut.mod_clock_en_o, v[11]);
         chk(uut.core_en_o, v[11]);
      end
   endtask
   task automatic t_seed;
      host.send(ADDR_MODCFG, 24'h030f00);
      n_seed = 0;
      n_busy = 0;
      host.send(ADDR_FRAC, 24'h123456);
      chk(24'(n_seed), 24'h000001);
      // sync bit clear: the write must not pass through the retimer
      chk(24'(n_busy), 24'h000000);
      chk(uut.frac_setting_o, 24'h123456);
      host.send(ADDR_MODCFG, 24'h030e00);
      host.send(ADDR_FRAC, 24'hfedcba);
      chk(24'(n_seed), 24'h000001);
      chk(uut.frac_setting_o, 24'hfedcba);
   endtask
   task automatic t_sync;
      host.send(ADDR_MODCFG, 24'h030e10);
      n_busy = 0;
      n_upd = 0;
      host.send(ADDR_FRAC, 24'habcdef);
      chk(uut.frac_setting_o, 24'habcdef);
      chk({23'h000000, n_busy != 0}, 24'h000001);
      host.send(ADDR_INT, 24'h0fffff);
      chk(uut.int_setting_o, 19'h7ffff);
      host.send(ADDR_AUX1A, 24'h5a5a5a);
      chk(uut.aux1a_o, 24'h5a5a5a);
      // only the integer and fractional writes count as frequency changes
      chk(24'(n_upd), 24'h000002);
   endtask
   task automatic t_read(input logic [4:0] a, input logic [23:0] exp);
      @(posedge ref_clk_i);
      #1 rd_addr_i = a;
      repeat (2) @(posedge ref_clk_i);
      #1 chk(uut.rd_data_o, exp);
   endtask
   initial begin
      repeat (20) @(posedge ref_clk_i);
      #1 sys_rst_i = 1'b0;
      t_reset();
      t_modes();
      t_seed();
      t_sync();
      t_read(ADDR_MODCFG, 24'h030e10);
      t_read(ADDR_AUX1A, 24'h5a5a5a);
      t_read(5'h1f, 24'h000000);
      tally_and_finish();
   end
endmodule
`default_nettype wire
